/* rtl/coep_pkg.sv */
// Shared constants and types for the complementary output event phase block.
package coep_pkg;

    localparam int unsigned COEP_SRC_W   = 8;
    localparam int unsigned COEP_CNT_W   = 6;
    localparam int unsigned COEP_ADDR_W  = 8;
    localparam int unsigned COEP_DATA_W  = 32;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] COEP_OFF_RISE_SRC   = 8'h00;
    localparam logic [7:0] COEP_OFF_RISE_PHASE = 8'h04;
    localparam logic [7:0] COEP_OFF_FALL_PHASE = 8'h08;
    localparam logic [7:0] COEP_OFF_STATUS     = 8'h0c;

    // Register indices produced by the address decoder.
    localparam logic [2:0] COEP_IDX_RISE_SRC   = 3'h0;
    localparam logic [2:0] COEP_IDX_RISE_PHASE = 3'h1;
    localparam logic [2:0] COEP_IDX_FALL_PHASE = 3'h2;
    localparam logic [2:0] COEP_IDX_STATUS     = 3'h3;
    localparam logic [2:0] COEP_IDX_NONE       = 3'h4;

    // Source enable bit positions.
    localparam int unsigned COEP_BIT_OSC   = 7;
    localparam int unsigned COEP_BIT_MOD2  = 6;
    localparam int unsigned COEP_BIT_CAP2  = 5;
    localparam int unsigned COEP_BIT_CAP1  = 4;
    localparam int unsigned COEP_BIT_LOGIC = 3;
    localparam int unsigned COEP_BIT_CMP2  = 2;
    localparam int unsigned COEP_BIT_CMP1  = 1;
    localparam int unsigned COEP_BIT_PIN   = 0;

    // Status register field positions.
    localparam int unsigned COEP_ST_SRC_LSB   = 0;
    localparam int unsigned COEP_ST_RBUSY     = 8;
    localparam int unsigned COEP_ST_FBUSY     = 9;
    localparam int unsigned COEP_ST_LEVEL     = 10;

    // Values after reset, plus the count constants one and zero.
    localparam logic [7:0] COEP_RST_RISE_SRC = 8'h00;
    localparam logic [5:0] COEP_RST_PHASE    = 6'h00;
    localparam logic [5:0] COEP_CNT_ONE      = 6'h01;
    localparam logic [5:0] COEP_CNT_ZERO     = 6'h00;

    // AXI response codes.
    localparam logic [1:0] COEP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] COEP_RESP_DECERR = 2'h3;

    typedef enum logic [0:0] {
        COEP_IDLE  = 1'b0,
        COEP_COUNT = 1'b1
    } coep_dly_state_t;

endpackage

/* rtl/coep_sync.sv */
// Two-stage synchroniser for the event source inputs.
`timescale 1ns/100ps
module coep_sync
    import coep_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [COEP_SRC_W-1:0] async_in,
    output logic      [COEP_SRC_W-1:0] sync_out
);
    import coep_pkg::*;

    logic [COEP_SRC_W-1:0] stage1;
    logic [COEP_SRC_W-1:0] next_stage1;
    logic [COEP_SRC_W-1:0] next_sync_out;

    always_comb
    begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stage1   <= COEP_RST_RISE_SRC;
            sync_out <= COEP_RST_RISE_SRC;
        end
        else
        begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

/* rtl/coep_phase_delay.sv */
// Delays a one-cycle edge event by a programmable number of clock periods.
`timescale 1ns/100ps
module coep_phase_delay
    import coep_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  event_in,
    input  wire logic [COEP_CNT_W-1:0] count,
    output logic                       event_out,
    output logic                       busy
);
    import coep_pkg::*;

    coep_dly_state_t       state;
    coep_dly_state_t       next_state;
    logic [COEP_CNT_W-1:0] remain;
    logic [COEP_CNT_W-1:0] next_remain;

    // A new event with a nonzero count while counting restarts the count, so an earlier edge is lost unless it is due in that same cycle.
    always_comb
    begin
        next_state  = state;
        next_remain = remain;
        if (event_in && (count != COEP_CNT_ZERO))
        begin
            next_state  = COEP_COUNT;
            next_remain = count;
        end
        else
        begin
            case (state)
                COEP_IDLE:
                begin
                    next_state = COEP_IDLE;
                end
                COEP_COUNT:
                begin
                    next_remain = remain - COEP_CNT_ONE;
                    if (remain == COEP_CNT_ONE)
                    begin
                        next_state = COEP_IDLE;
                    end
                end
                default:
                begin
                    next_state = COEP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state  <= COEP_IDLE;
            remain <= COEP_CNT_ZERO;
        end
        else
        begin
            state  <= next_state;
            remain <= next_remain;
        end
    end

    assign event_out = (event_in && (count == COEP_CNT_ZERO))                      // [RULE6]
                     || ((state == COEP_COUNT) && (remain == COEP_CNT_ONE));     // [RULE2] [RULE3]
    assign busy      = (state == COEP_COUNT);

    property p_zero_pass; // [RULE6]
        @(posedge ref_clk) disable iff (rst)
        (event_in && (count == COEP_CNT_ZERO)) |-> event_out;
    endproperty
    a_zero_pass: assert property (p_zero_pass) // [RULE6]
        else $error("Zero phase count did not pass the event through.");

    property p_no_early; // [RULE2] [RULE3]
        @(posedge ref_clk) disable iff (rst)
        (event_in && (count > COEP_CNT_ONE)) ##1 !event_in |-> !event_out;
    endproperty
    a_no_early: assert property (p_no_early) // [RULE2] [RULE3]
        else $error("Delayed event appeared too early.");

    property p_delay_one; // [RULE2] [RULE3]
        @(posedge ref_clk) disable iff (rst)
        (event_in && (count == COEP_CNT_ONE)) |=> event_out;
    endproperty
    a_delay_one: assert property (p_delay_one) // [RULE2] [RULE3]
        else $error("Count of one did not delay the event by one period.");

    property p_delay_three; // [RULE2] [RULE3]
        @(posedge ref_clk) disable iff (rst)
        (event_in && (count == 6'h03)) ##1 (!event_in)[*2] |=> event_out;
    endproperty
    a_delay_three: assert property (p_delay_three) // [RULE2] [RULE3]
        else $error("Count of three did not delay the event by three periods.");

endmodule

/* rtl/coep_top.sv */
// Event input front end with source enables, phase delays and an AXI4-Lite register slave.
// Behaviour
// [RULE1] Set enable bits let their sources cause rising events; cleared bits ignore them.
// [RULE2] Each rising event is delayed by the six-bit rising phase count in clock periods.
// [RULE3] Each falling event is delayed by the six-bit falling phase count in clock periods.
// [RULE4] Phase register bits 7 and 6 read as zero and ignore writes.
// [RULE5] Power-on reset clears enables; other resets clear enables, keep phase counts.
// [RULE6] A phase count of zero passes the event with only synchronisation delay.
`timescale 1ns/100ps
module coep_top
    import coep_pkg::*;
(
    input  wire logic                             ref_clk,
    input  wire logic                             rst,
    input  wire logic                             soft_rst,
    input  wire logic                             numeric_oscillator_output,
    input  wire logic                             second_modulator_output,
    input  wire logic                             capture_unit_two,
    input  wire logic                             capture_unit_one,
    input  wire logic                             logic_cell_one,
    input  wire logic                             comparator2_output,
    input  wire logic                             comparator1_output,
    input  wire logic                             pin_routing_select,
    output logic                                  rise_event,
    output logic                                  fall_event,
    output logic                                  phase_level,
    input  wire logic [coep_pkg::COEP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [coep_pkg::COEP_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [coep_pkg::COEP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [coep_pkg::COEP_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready
);
    import coep_pkg::*;

    function automatic logic [2:0] coep_decode(input logic [COEP_ADDR_W-1:0] addr);
        logic [2:0] idx;
        idx = COEP_IDX_NONE;
        case (addr)
            COEP_OFF_RISE_SRC:   idx = COEP_IDX_RISE_SRC;
            COEP_OFF_RISE_PHASE: idx = COEP_IDX_RISE_PHASE;
            COEP_OFF_FALL_PHASE: idx = COEP_IDX_FALL_PHASE;
            COEP_OFF_STATUS:     idx = COEP_IDX_STATUS;
            default:             idx = COEP_IDX_NONE;
        endcase
        return idx;
    endfunction

    // Register state.
    logic [COEP_SRC_W-1:0]  rise_source_enable;
    logic [COEP_CNT_W-1:0]  rise_phase_count;
    logic [COEP_CNT_W-1:0]  fall_phase_count;
    logic [COEP_SRC_W-1:0]  next_rise_source_enable;
    logic [COEP_CNT_W-1:0]  next_rise_phase_count;
    logic [COEP_CNT_W-1:0]  next_fall_phase_count;

    // Bus state.
    logic                   aw_held;
    logic                   w_held;
    logic [COEP_ADDR_W-1:0] aw_addr;
    logic [COEP_DATA_W-1:0] w_data;
    logic                   w_lane0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [COEP_DATA_W-1:0] rdata;
    logic                   next_aw_held;
    logic                   next_w_held;
    logic [COEP_ADDR_W-1:0] next_aw_addr;
    logic [COEP_DATA_W-1:0] next_w_data;
    logic                   next_w_lane0;
    logic                   next_bvalid;
    logic [1:0]             next_bresp;
    logic                   next_rvalid;
    logic [1:0]             next_rresp;
    logic [COEP_DATA_W-1:0] next_rdata;
    logic                   do_write;
    logic [2:0]             wr_idx;
    logic [2:0]             rd_idx;

    // Event path state.
    logic [COEP_SRC_W-1:0]  src_raw;
    logic [COEP_SRC_W-1:0]  src_sync;
    logic                   combined;
    logic                   combined_d;
    logic                   rise_edge;
    logic                   fall_edge;
    logic                   rise_delayed;
    logic                   fall_delayed;
    logic                   rise_busy;
    logic                   fall_busy;
    logic                   next_combined_d;
    logic                   next_rise_event;
    logic                   next_fall_event;
    logic                   next_phase_level;

    // Internal peripherals may run on other clocks, so every source is synchronised.
    assign src_raw = {numeric_oscillator_output, second_modulator_output,
                      capture_unit_two, capture_unit_one, logic_cell_one,
                      comparator2_output, comparator1_output, pin_routing_select};

    coep_sync u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (src_raw),
        .sync_out (src_sync)
    );

    assign combined  = |(src_sync & rise_source_enable);                           // [RULE1]
    assign rise_edge = combined && !combined_d;                                    // [RULE1]
    assign fall_edge = !combined && combined_d;

    coep_phase_delay u_rise_delay (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .event_in  (rise_edge),
        .count     (rise_phase_count),                                             // [RULE2]
        .event_out (rise_delayed),
        .busy      (rise_busy)
    );

    coep_phase_delay u_fall_delay (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .event_in  (fall_edge),
        .count     (fall_phase_count),                                             // [RULE3]
        .event_out (fall_delayed),
        .busy      (fall_busy)
    );

    // Rise wins when both delayed events land together, so the level never misses a cycle.
    always_comb
    begin
        next_combined_d  = combined;
        next_rise_event  = rise_delayed;
        next_fall_event  = fall_delayed;
        next_phase_level = phase_level;
        if (rise_delayed)
        begin
            next_phase_level = 1'b1;
        end
        else if (fall_delayed)
        begin
            next_phase_level = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            combined_d  <= 1'b0;
            rise_event  <= 1'b0;
            fall_event  <= 1'b0;
            phase_level <= 1'b0;
        end
        else
        begin
            combined_d  <= next_combined_d;
            rise_event  <= next_rise_event;
            fall_event  <= next_fall_event;
            phase_level <= next_phase_level;
        end
    end

    // Address and data are held separately so the master may present them in either order.
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;

    assign do_write = aw_held && w_held && !bvalid;
    assign wr_idx   = coep_decode(aw_addr);
    assign rd_idx   = coep_decode(s_axi_araddr);

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held  = 1'b1;
            next_w_data  = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_idx == COEP_IDX_NONE) ? COEP_RESP_DECERR : COEP_RESP_OKAY;
        end
        else if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = COEP_RESP_OKAY;
            next_rdata  = '0;
            case (rd_idx)
                COEP_IDX_RISE_SRC:   next_rdata[COEP_SRC_W-1:0] = rise_source_enable;
                COEP_IDX_RISE_PHASE: next_rdata[COEP_CNT_W-1:0] = rise_phase_count;  // [RULE4]
                COEP_IDX_FALL_PHASE: next_rdata[COEP_CNT_W-1:0] = fall_phase_count;  // [RULE4]
                COEP_IDX_STATUS:
                begin
                    next_rdata[COEP_ST_SRC_LSB +: COEP_SRC_W] = src_sync;
                    next_rdata[COEP_ST_RBUSY]                 = rise_busy;
                    next_rdata[COEP_ST_FBUSY]                 = fall_busy;
                    next_rdata[COEP_ST_LEVEL]                 = phase_level;
                end
                default:             next_rresp = COEP_RESP_DECERR;
            endcase
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_lane0 <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= COEP_RESP_OKAY;
            rvalid  <= 1'b0;
            rresp   <= COEP_RESP_OKAY;
            rdata   <= '0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_lane0 <= next_w_lane0;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
        end
    end

    // Phase counts take a defined zero at power-on even though software must not rely on it.
    always_comb
    begin
        next_rise_source_enable = rise_source_enable;
        next_rise_phase_count   = rise_phase_count;
        next_fall_phase_count   = fall_phase_count;
        if (do_write && w_lane0 && !soft_rst)                                     // [RULE5]
        begin
            case (wr_idx)
                COEP_IDX_RISE_SRC:   next_rise_source_enable = w_data[COEP_SRC_W-1:0];
                COEP_IDX_RISE_PHASE: next_rise_phase_count   = w_data[COEP_CNT_W-1:0]; // [RULE4]
                COEP_IDX_FALL_PHASE: next_fall_phase_count   = w_data[COEP_CNT_W-1:0]; // [RULE4]
                default:             next_rise_source_enable = rise_source_enable;
            endcase
        end
        if (soft_rst)
        begin
            next_rise_source_enable = COEP_RST_RISE_SRC;                           // [RULE5]
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rise_source_enable <= COEP_RST_RISE_SRC;                               // [RULE5]
            rise_phase_count   <= COEP_RST_PHASE;
            fall_phase_count   <= COEP_RST_PHASE;
        end
        else
        begin
            rise_source_enable <= next_rise_source_enable;
            rise_phase_count   <= next_rise_phase_count;
            fall_phase_count   <= next_fall_phase_count;
        end
    end

    property p_masked_source; // [RULE1]
        @(posedge ref_clk) disable iff (rst)
        ((src_sync & rise_source_enable) == COEP_RST_RISE_SRC) |-> !combined;
    endproperty
    a_masked_source: assert property (p_masked_source) // [RULE1]
        else $error("A disabled source produced an event.");

    property p_rise_reaches_out; // [RULE1] [RULE6]
        @(posedge ref_clk) disable iff (rst)
        (rise_edge && (rise_phase_count == COEP_CNT_ZERO)) |=> rise_event;
    endproperty
    a_rise_reaches_out: assert property (p_rise_reaches_out) // [RULE1] [RULE6]
        else $error("Rising event with zero phase did not reach the output.");

    property p_fall_reaches_out; // [RULE3] [RULE6]
        @(posedge ref_clk) disable iff (rst)
        (fall_edge && (fall_phase_count == COEP_CNT_ZERO)) |=> fall_event;
    endproperty
    a_fall_reaches_out: assert property (p_fall_reaches_out) // [RULE3] [RULE6]
        else $error("Falling event with zero phase did not reach the output.");

    property p_reserved_zero; // [RULE4]
        @(posedge ref_clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && ((rd_idx == COEP_IDX_RISE_PHASE)
            || (rd_idx == COEP_IDX_FALL_PHASE))) |=> (s_axi_rdata[31:6] == 26'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RULE4]
        else $error("Reserved phase register bits did not read as zero.");

    property p_soft_reset; // [RULE5]
        @(posedge ref_clk) disable iff (rst)
        soft_rst |=> (rise_source_enable == COEP_RST_RISE_SRC)
            && $stable(rise_phase_count) && $stable(fall_phase_count);
    endproperty
    a_soft_reset: assert property (p_soft_reset) // [RULE5]
        else $error("Soft reset did not clear enables or disturbed phase counts.");

    property p_write_ack; // [RULE2]
        @(posedge ref_clk) disable iff (rst)
        (do_write && w_lane0 && (wr_idx == COEP_IDX_RISE_PHASE) && !soft_rst)
            |=> (rise_phase_count == $past(w_data[5:0])) && s_axi_bvalid;
    endproperty
    a_write_ack: assert property (p_write_ack) // [RULE2]
        else $error("Rising phase write was not stored or acknowledged.");

endmodule

/* verif/coep_src_model.sv */
// Far-side model of the peripheral outputs and the routed pin.
`timescale 1ns/100ps
module coep_src_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] want,
    output logic      [7:0] src
);
    // Levels move just after an edge, as from peripherals on the same clock.
    always_ff @(posedge ref_clk)
    begin
        src <= want;
    end
endmodule

/* verif/complementary_output_event_phase_bench.sv */
// Randomised self-checking bench for the event phase front end.
`timescale 1ns/100ps
module complementary_output_event_phase_bench;
    import coep_pkg::*;
    logic        ref_clk = 0, rst = 1, soft_rst = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic [7:0]  awaddr = 0, araddr = 0, want = 0;
    logic [31:0] wdata = 0, rd_data;
    logic [1:0]  rd_resp, wr_resp;
    logic        lvl_seen;
    wire         awready, wready, bvalid, arready, rvalid, rise_ev, fall_ev, lvl;
    wire  [1:0]  bresp, rresp;
    wire  [7:0]  src;
    wire  [31:0] rdata;
    int          bad_count = 0, compares = 0, cyc = 0, seed = 92, b0, b1, c, n, m;
    // Falling edges from a level request to a zero-phase event: the model register,
    // two synchroniser stages, the output register and the edge that counts it.
    localparam int SYNC_LAT = 5;
    coep_src_model peers (.ref_clk(ref_clk), .want(want), .src(src));
    coep_top dut (
        .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst),
        .numeric_oscillator_output(src[7]), .second_modulator_output(src[6]),
        .capture_unit_two(src[5]), .capture_unit_one(src[4]), .logic_cell_one(src[3]),
        .comparator2_output(src[2]), .comparator1_output(src[1]), .pin_routing_select(src[0]),
        .rise_event(rise_ev), .fall_event(fall_ev), .phase_level(lvl),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1)
    );
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            test_done;
        end
    end
    task automatic test_done;
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Handshakes are looked at on the falling edge, where they already hold the value
    // of the next rising edge, so the bench never races the design's own updates.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!tb)
        begin
            @(negedge ref_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            wr_resp = bresp;
            @(posedge ref_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, t;
        t = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        while (!t)
        begin
            @(negedge ref_clk);
            ta = arvalid & arready;
            t = rvalid;
            rd_data = rdata;
            rd_resp = rresp;
            @(posedge ref_clk);
            if (ta)
                arvalid <= 1'b0;
        end
    endtask
    task automatic meas(input int i, input logic lv, output int cnt);
        want[i] <= lv;
        cnt = 0;
        do
        begin
            @(negedge ref_clk);
            cnt++;
        end
        while ((lv ? rise_ev : fall_ev) !== 1'b1 && cnt < 120);
        lvl_seen = lvl;
        @(posedge ref_clk);
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(COEP_OFF_RISE_SRC);
        chk(rd_data, 32'h0);
        rd(8'h40);
        chk(rd_resp, COEP_RESP_DECERR);
        wr(8'h40, 32'hff);
        chk(wr_resp, COEP_RESP_DECERR);
        want <= 8'hfe;
        @(posedge ref_clk);
        meas(0, 1'b1, c);
        chk(c, 120);
        want <= 8'h00;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            wr(COEP_OFF_RISE_SRC, 32'h1 << i);
            rd(COEP_OFF_RISE_SRC);
            chk(rd_data, 32'h1 << i);
            wr(COEP_OFF_RISE_PHASE, 32'h0);
            wr(COEP_OFF_FALL_PHASE, 32'h0);
            meas(i, 1'b1, b0);
            chk(b0, SYNC_LAT);
            chk(lvl_seen, 1'b1);
            rd(COEP_OFF_STATUS);
            chk(rd_data, (32'h1 << i) | (32'h1 << COEP_ST_LEVEL));
            meas(i, 1'b0, b1);
            chk(b1, SYNC_LAT);
            chk(lvl_seen, 1'b0);
            n = (i == 0) ? 63 : {$random(seed)} % 64;
            m = (i == 7) ? 63 : {$random(seed)} % 64;
            wr(COEP_OFF_RISE_PHASE, 32'hffffffc0 | n);
            wr(COEP_OFF_FALL_PHASE, m);
            chk(wr_resp, COEP_RESP_OKAY);
            rd(COEP_OFF_RISE_PHASE);
            chk(rd_data, n);
            meas(i, 1'b1, c);
            chk(c, b0 + n);
            meas(i, 1'b0, c);
            chk(c, b1 + m);
        end
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        rd(COEP_OFF_RISE_SRC);
        chk(rd_data, 32'h0);
        rd(COEP_OFF_RISE_PHASE);
        chk(rd_data, n);
        rd(COEP_OFF_FALL_PHASE);
        chk(rd_data, m);
        test_done;
    end
endmodule
